// ---- sdwp_pkg.sv ----
// Package of constants and types for the SMBus DAC write port
package sdwp_pkg;

  localparam logic [4:0] ADDR_FIXED = 5'h0b;
  localparam int ADDR_BITS = 7;
  localparam int CODE_BITS = 10;
  localparam int BYTE_BITS = 8;
  localparam int ACK_SLOT = 8;
  localparam int CMD_POWER_DOWN_REQUEST_BIT = 7;
  localparam int CMD_HI_MSB = 1;
  localparam logic [9:0] CODE_MID = 10'h200;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Straps read through two reset-high flops are real from the third edge
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_END = 2'h3;

  typedef enum logic [2:0] {
    SDWP_IDLE,
    SDWP_ADDR,
    SDWP_CMD,
    SDWP_DATA,
    SDWP_IGNORE
  } sdwp_state_e;

  // Edge and condition events seen on the sampled bus
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } sdwp_bus_ev_s;

endpackage

// ---- sdwp_sync.sv ----
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/10ps
module sdwp_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // Resets high to match an idle, pulled-up bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ---- sdwp_bus_detect.sv ----
// Edge, START and STOP detector for the synchronised bus lines
`timescale 1ns/10ps
module sdwp_bus_detect (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_s,
  input wire logic sda_s,
  output sdwp_pkg::sdwp_bus_ev_s ev
);

  logic scl_d;
  logic sda_d;
  logic next_scl_d;
  logic next_sda_d;

  always_comb begin
    next_scl_d = scl_s;
    next_sda_d = sda_s;
    ev.scl_rise = scl_s & ~scl_d;
    ev.scl_fall = ~scl_s & scl_d;
    ev.start = scl_s & scl_d & sda_d & ~sda_s;
    ev.stop = scl_s & scl_d & ~sda_d & sda_s;
    ev.sda = sda_s;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

endmodule

// ---- sdwp_smbus_dac_write_port.sv ----
// SMBus receive-only slave and DAC hold register, top level
`timescale 1ns/10ps
module sdwp_smbus_dac_write_port (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic power_down_request_b,
  input wire logic addr_strap_upper,
  input wire logic addr_strap_lower,
  output logic [9:0] dac_code,
  output logic dac_shutdown
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and bus events

  logic scl_s;
  logic sda_s;
  logic pd_b_s;
  logic strap_hi_s;
  logic strap_lo_s;
  sdwp_pkg::sdwp_bus_ev_s ev;

  sdwp_sync u_sync_scl (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(scl),
    .sync_out(scl_s)
  );
  sdwp_sync u_sync_sda (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(sda_in),
    .sync_out(sda_s)
  );
  sdwp_sync u_sync_pd (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(power_down_request_b),
    .sync_out(pd_b_s)
  );
  sdwp_sync u_sync_ahi (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(addr_strap_upper),
    .sync_out(strap_hi_s)
  );
  sdwp_sync u_sync_alo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(addr_strap_lower),
    .sync_out(strap_lo_s)
  );

  sdwp_bus_detect u_detect (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .ev(ev)
  );

  //////////////////////////////////////////////////////////////////////////
  // Protocol state

  sdwp_pkg::sdwp_state_e state;
  sdwp_pkg::sdwp_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic ack;
  logic next_ack;
  logic [6:0] own_addr;
  logic stage_power_down_request;
  logic next_stage_power_down_request;
  logic [1:0] stage_hi;
  logic [1:0] next_stage_hi;
  logic cmd_power_down_request;
  logic next_cmd_power_down_request;
  logic [9:0] next_dac_code;
  logic [1:0] init_cnt;
  logic [1:0] next_init_cnt;

  // fixed upper bits
  // Low bits follow the strap table, not the plain strap levels
  assign own_addr = {sdwp_pkg::ADDR_FIXED, strap_hi_s ^ strap_lo_s,
                     ~strap_hi_s};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_ack = ack;
    next_stage_power_down_request = stage_power_down_request;
    next_stage_hi = stage_hi;
    next_cmd_power_down_request = cmd_power_down_request;
    next_dac_code = dac_code;
    next_init_cnt = init_cnt;
    if (init_cnt != sdwp_pkg::INIT_END) begin
      next_init_cnt = init_cnt + 2'h1;
    end
    // Straps are caught once the synchronisers hold the real pin levels
    // midscale power-up code when both straps are high, else zero
    if (init_cnt == sdwp_pkg::INIT_LOAD) begin
      if (strap_hi_s && strap_lo_s) begin
        next_dac_code = sdwp_pkg::CODE_MID;
      end else begin
        next_dac_code = sdwp_pkg::CODE_ZERO;
      end
    end
    if (ev.stop) begin
      next_state = sdwp_pkg::SDWP_IDLE;
      next_ack = 1'b0;
      next_bit_cnt = 4'h0;
    end else if (ev.start) begin
      next_state = sdwp_pkg::SDWP_ADDR;
      next_ack = 1'b0;
      next_bit_cnt = 4'h0;
    end else if (state != sdwp_pkg::SDWP_IDLE &&
                 state != sdwp_pkg::SDWP_IGNORE) begin
      if (ev.scl_rise && bit_cnt <= sdwp_pkg::BIT_LAST) begin
        next_shift = {shift[6:0], ev.sda};
        next_bit_cnt = bit_cnt + 4'h1;
      end
      // Counting rises keeps the fall that ends a START out of the count
      if (ev.scl_fall && bit_cnt == sdwp_pkg::BIT_ACK) begin
        if (!ack) begin
          case (state)
            sdwp_pkg::SDWP_ADDR: begin
              if (shift[7:1] == own_addr && !shift[0]) begin
                next_ack = 1'b1;
              end else begin
                next_state = sdwp_pkg::SDWP_IGNORE;
              end
            end
            sdwp_pkg::SDWP_CMD: next_ack = 1'b1;
            sdwp_pkg::SDWP_DATA: next_ack = 1'b1;
            default: next_ack = 1'b0;
          endcase
        end else begin
          next_ack = 1'b0;
          next_bit_cnt = 4'h0;
          case (state)
            sdwp_pkg::SDWP_ADDR: next_state = sdwp_pkg::SDWP_CMD;
            sdwp_pkg::SDWP_CMD: begin
              next_stage_power_down_request = shift[sdwp_pkg::CMD_POWER_DOWN_REQUEST_BIT];
              next_stage_hi = shift[sdwp_pkg::CMD_HI_MSB:0];
              next_state = sdwp_pkg::SDWP_DATA;
            end
            sdwp_pkg::SDWP_DATA: begin
              next_dac_code = {stage_hi, shift};
              next_cmd_power_down_request = stage_power_down_request;
              // Further bytes are not part of Write Byte, so drop them
              next_state = sdwp_pkg::SDWP_IGNORE;
            end
            default: next_state = sdwp_pkg::SDWP_IGNORE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sdwp_pkg::SDWP_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack <= 1'b0;
      stage_power_down_request <= 1'b0;
      stage_hi <= 2'h0;
      cmd_power_down_request <= 1'b0;
      dac_code <= 10'h000;
      init_cnt <= 2'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      ack <= next_ack;
      stage_power_down_request <= next_stage_power_down_request;
      stage_hi <= next_stage_hi;
      cmd_power_down_request <= next_cmd_power_down_request;
      dac_code <= next_dac_code;
      init_cnt <= next_init_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sda_out = 1'b0;
  assign sda_oe = ack;

  assign dac_shutdown = cmd_power_down_request | ~pd_b_s;

endmodule

// ---- sdwp_chk.sv ----
// Checker for the SMBus DAC write port
`timescale 1ns/10ps
module sdwp_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic power_down_request_b,
  input wire logic addr_strap_upper,
  input wire logic addr_strap_lower,
  input wire logic [9:0] dac_code,
  input wire logic dac_shutdown
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  a_ack_clk_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("ack raised with clock high");
  // Sync lag lets a change land on the first two high samples only
  a_ack_held: assert property (scl [*3] |-> $stable(sda_oe))
    else $error("data drive moved with clock high");
  a_ack_bounded: assert property ($rose(sda_oe) |-> ##[1:12] !sda_oe)
    else $error("ack held too long");
  a_pin_power_down_request: assert property
    ((!power_down_request_b) [*3] |-> dac_shutdown)
    else $error("pin low without shutdown");
  a_code_clk_low: assert property
    ($changed(dac_code) && $past(rst_b, 4) |-> !scl)
    else $error("code changed with clock high");
  a_reset_code: assert property ($rose(rst_b) |-> ##3 dac_code ==
    (addr_strap_upper && addr_strap_lower ? sdwp_pkg::CODE_MID :
    sdwp_pkg::CODE_ZERO))
    else $error("wrong reset code");
  a_power_down_request_cause: assert property ($changed(dac_shutdown) |-> !scl ||
    $past(power_down_request_b, 4) != power_down_request_b)
    else $error("shutdown moved without cause");
endmodule
bind sdwp_smbus_dac_write_port sdwp_chk u_chk (.*);

// ---- sdwp_host.sv ----
// SMBus master model driving the clock and data lines
`timescale 1ns/10ps
module sdwp_host (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    #40 sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask
  task automatic stop();
    #40 sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      #40 sda_drv = w[i];
      #40 scl = 1'b1;
      #40 ack = ~sda;
      #40 scl = 1'b0;
    end
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the SMBus DAC write port
`timescale 1ns/10ps
module tb;
  logic core_clk, rst_b, power_down_request_b, scl, sda_drv, sda_out;
  logic sda_oe, addr_strap_upper, addr_strap_lower, dac_shutdown, es;
  logic [9:0] dac_code, ec;
  logic [7:0] a, c, d;
  logic [2:0] ea, ak;
  logic [40:0] rows [8];
  wire logic sda_in;
  int err_count;
  int tests_run;
  // Pull-up: low when either party pulls
  assign sda_in = sda_drv & (~sda_oe | sda_out);
  sdwp_smbus_dac_write_port u_sdwp_smbus_dac_write_port (.*);
  sdwp_host u_host (.scl(scl), .sda_drv(sda_drv), .sda(sda_in));
  task automatic check(input string what, input logic [9:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Code lands about three clocks after the last ack
  task automatic wr(input logic [7:0] x, y, z, output logic [2:0] k);
    u_host.start();
    u_host.send(x, k[2]);
    u_host.send(y, k[1]);
    u_host.send(z, k[0]);
    #100;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_b = 1'b0;
    power_down_request_b = 1'b1;
    {addr_strap_upper, addr_strap_lower} = 2'h3;
    rows = '{{2'h3, 1'h1, 8'h58, 8'h02, 8'h34, 3'h7, 10'h234, 1'h0},
      {2'h0, 1'h1, 8'h5a, 8'hfd, 8'hff, 3'h7, 10'h1ff, 1'h1},
      {2'h1, 1'h1, 8'h5e, 8'h03, 8'h00, 3'h7, 10'h300, 1'h0},
      {2'h2, 1'h1, 8'h5c, 8'h00, 8'h01, 3'h7, 10'h001, 1'h0},
      {2'h2, 1'h1, 8'h5a, 8'h03, 8'h02, 3'h0, 10'h001, 1'h0},
      {2'h2, 1'h1, 8'h5d, 8'h03, 8'h02, 3'h0, 10'h001, 1'h0},
      {2'h2, 1'h0, 8'h5c, 8'h01, 8'h80, 3'h7, 10'h180, 1'h1},
      {2'h2, 1'h1, 8'h5e, 8'h03, 8'h02, 3'h0, 10'h180, 1'h0}};
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge core_clk);
    check("reset code", dac_code, 10'h200);
    for (int r = 0; r < 8; r++) begin
      {addr_strap_upper, addr_strap_lower, power_down_request_b,
        a, c, d, ea, ec, es} = rows[r];
      wr(a, c, d, ak);
      check("ack", 10'(ak), 10'(ea));
      check("code", dac_code, ec);
      check("shutdown", 10'(dac_shutdown), 10'(es));
      u_host.stop();
    end
    u_host.start();
    u_host.send(8'h5c, ak[2]);
    u_host.send(8'h83, ak[1]);
    u_host.stop();
    check("early stop code", dac_code, 10'h180);
    check("early stop shutdown", 10'(dac_shutdown), 10'h0);
    u_host.start();
    u_host.send(8'h5c, ak[2]);
    u_host.send(8'h02, ak[1]);
    wr(8'h5c, 8'h01, 8'h55, ak);
    check("restart ack", 10'(ak), 10'h7);
    check("restart code", dac_code, 10'h155);
    u_host.stop();
    {addr_strap_upper, addr_strap_lower} = 2'h0;
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge core_clk);
    check("reset zero", dac_code, 10'h000);
    summarize();
  end
endmodule
